// File: hw/cmt_pkg.sv
// Package for the compare match period timer: register map, fields, resets, divider ratios.
// Assumes a 32-bit APB slave with word-aligned registers.
package cmt_pkg;
   // Printed offsets are not all multiples of four, so each is kept as an index
   localparam logic [3:0]  IDX_START   = 4'h0;
   localparam logic [3:0]  IDX_CTRL    = 4'h1;
   localparam logic [3:0]  IDX_COUNT   = 4'h2;
   localparam logic [3:0]  IDX_PERIOD  = 4'h3;
   localparam logic [3:0]  IDX_IRQ_ST  = 4'h4;
   localparam logic [3:0]  IDX_IRQ_MSK = 4'h5;
   localparam logic [11:0] ADDR_START   = {6'h00, IDX_START, 2'h0};
   localparam logic [11:0] ADDR_CTRL    = {6'h00, IDX_CTRL, 2'h0};
   localparam logic [11:0] ADDR_COUNT   = {6'h00, IDX_COUNT, 2'h0};
   localparam logic [11:0] ADDR_PERIOD  = {6'h00, IDX_PERIOD, 2'h0};
   localparam logic [11:0] ADDR_IRQ_ST  = {6'h00, IDX_IRQ_ST, 2'h0};
   localparam logic [11:0] ADDR_IRQ_MSK = {6'h00, IDX_IRQ_MSK, 2'h0};
   // Control/status fields
   localparam int FLAG_BIT  = 7;
   localparam int SPARE_BIT = 6;
   localparam int START_BIT = 0;
   localparam int SPARE_START_BIT = 1;
   // Reset values
   localparam logic [15:0] COUNT_RESET  = 16'h0000;
   localparam logic [15:0] PERIOD_RESET = 16'hffff;
   // Prescaler terminal counts (ratio minus one)
   localparam logic [5:0]  DIV4_LAST  = 6'h03;
   localparam logic [5:0]  DIV8_LAST  = 6'h07;
   localparam logic [5:0]  DIV16_LAST = 6'h0f;
   localparam logic [5:0]  DIV64_LAST = 6'h3f;
   typedef enum logic [1:0]
   {
      CMT_DIV4  = 2'h0,
      CMT_DIV8  = 2'h1,
      CMT_DIV16 = 2'h2,
      CMT_DIV64 = 2'h3
   } cmt_div_e;
endpackage

// File: hw/cmt_timer.sv
// Compare match period timer with APB register access and a match interrupt.
// Assumes a single 250 MHz pclk and an APB master that follows the usual two-phase protocol.
//
// Implementation choices: the address map and the APB slave port.
module cmt_timer
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             dma_request,
   output logic             irq
);
   // Registers
   logic [1:0]  start_reg;
   logic        match_flag;
   logic        spare_bit;
   logic [1:0]  clock_select;
   logic [15:0] count_value;
   logic [15:0] period_constant;
   logic        flag_seen;
   logic        irq_status;
   logic        irq_mask;
   logic [5:0]  prescale;

   // Bus decode, single-cycle answer
   wire access_phase = psel & penable;
   wire wr_en        = access_phase & pwrite;
   wire rd_en        = access_phase & ~pwrite;
   wire hit_start    = (paddr == cmt_pkg::ADDR_START);
   wire hit_ctrl     = (paddr == cmt_pkg::ADDR_CTRL);
   wire hit_count    = (paddr == cmt_pkg::ADDR_COUNT);
   wire hit_period   = (paddr == cmt_pkg::ADDR_PERIOD);
   wire hit_irq_st   = (paddr == cmt_pkg::ADDR_IRQ_ST);
   wire hit_irq_msk  = (paddr == cmt_pkg::ADDR_IRQ_MSK);
   wire hit_any      = hit_start | hit_ctrl | hit_count | hit_period | hit_irq_st | hit_irq_msk;
   assign pready  = 1'b1;
   assign pslverr = access_phase & ~hit_any;

   // Prescaler terminal count per select code
   logic [5:0] div_last;
   always_comb
   begin
      unique case (cmt_pkg::cmt_div_e'(clock_select))
         cmt_pkg::CMT_DIV4:  div_last = cmt_pkg::DIV4_LAST;
         cmt_pkg::CMT_DIV8:  div_last = cmt_pkg::DIV8_LAST;
         cmt_pkg::CMT_DIV16: div_last = cmt_pkg::DIV16_LAST;
         cmt_pkg::CMT_DIV64: div_last = cmt_pkg::DIV64_LAST;
      endcase
   end

   wire running    = start_reg[cmt_pkg::START_BIT];
   wire tick       = running & (prescale >= div_last);
   wire equal      = (count_value == period_constant);
   wire match_tick = tick & equal;
   wire [15:0] next_count = match_tick ? cmt_pkg::COUNT_RESET : 16'(count_value + 16'h0001);

   // Flag clear only when 0 written after the flag was read as 1
   wire flag_clear = wr_en & hit_ctrl & ~pwdata[cmt_pkg::FLAG_BIT] & flag_seen;

   // Control/status view, reserved bits read zero
   wire [15:0] ctrl_view = {8'h00, match_flag, spare_bit, 4'h0, clock_select};

   // Read mux from current state
   assign prdata = !rd_en       ? 32'h00000000 :
                   hit_start    ? {30'h00000000, start_reg} :
                   hit_ctrl     ? {16'h0000, ctrl_view} :
                   hit_count    ? {16'h0000, count_value} :
                   hit_period   ? {16'h0000, period_constant} :
                   hit_irq_st   ? {31'h00000000, irq_status} :
                   hit_irq_msk  ? {31'h00000000, irq_mask} : 32'h00000000;

   assign dma_request = match_tick;
   assign irq         = irq_status & irq_mask;

   // Prescaler restarts while halted so the first pulse is a full period
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prescale <= 6'h00;
      else if (!running || tick)
         prescale <= 6'h00;
      else
         prescale <= prescale + 6'h01;
   end

   // Counter: a bus write wins over counting in the same cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         count_value <= cmt_pkg::COUNT_RESET;
      else if (wr_en && hit_count)
         count_value <= pwdata[15:0];
      else if (tick)
         count_value <= next_count;
   end

   // Period constant
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         period_constant <= cmt_pkg::PERIOD_RESET;
      else if (wr_en && hit_period)
         period_constant <= pwdata[15:0];
   end

   // Start register, bit 1 kept as plain storage
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         start_reg <= 2'h0;
      else if (wr_en && hit_start)
         start_reg <= pwdata[1:0];
   end

   // Control fields
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         spare_bit    <= 1'b0;
         clock_select <= 2'h0;
      end
      else if (wr_en && hit_ctrl)
      begin
         spare_bit    <= pwdata[cmt_pkg::SPARE_BIT];
         clock_select <= pwdata[1:0];
      end
   end

   // Match flag: set wins over clear; writing 1 has no effect
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         match_flag <= 1'b0;
      else if (match_tick)
         match_flag <= 1'b1;
      else if (flag_clear)
         match_flag <= 1'b0;
   end

   // Remembers a read of the flag as 1, armed until a clear write or the flag falls
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         flag_seen <= 1'b0;
      else if (!match_flag || flag_clear)
         flag_seen <= 1'b0;
      else if (rd_en && hit_ctrl)
         flag_seen <= 1'b1;
   end

   // Interrupt status, write one to clear, set wins
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq_status <= 1'b0;
      else if (match_tick)
         irq_status <= 1'b1;
      else if (wr_en && hit_irq_st && pwdata[0])
         irq_status <= 1'b0;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq_mask <= 1'b0;
      else if (wr_en && hit_irq_msk)
         irq_mask <= pwdata[0];
   end

   // Checking helpers: cycles since the last prescaled pulse, counted apart from
   // the prescaler so that the ratio check does not lean on the divider it guards.
   // A select change in mid-period makes the next gap shorter or longer by design, so the
   // gap that follows such a change is not judged.
   logic [6:0] gap_count;
   logic [1:0] gap_select;
   logic       gap_valid;
   wire  [6:0] gap_expect  = (clock_select == 2'h3) ? 7'h3f :
                             7'((7'h04 << clock_select) - 7'h01);
   wire        sel_changed = (clock_select != gap_select);

   // Gap counter restarts when halted or on a pulse
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         gap_count <= 7'h00;
      else if (!running || tick)
         gap_count <= 7'h00;
      else
         gap_count <= gap_count + 7'h01;
   end

   // Select seen one cycle ago, to spot a change
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         gap_select <= 2'h0;
      else
         gap_select <= clock_select;
   end

   // A gap is trusted after a halt or a pulse, not after a select change
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         gap_valid <= 1'b0;
      else if (running && sel_changed)
         gap_valid <= 1'b0;
      else if (!running || tick)
         gap_valid <= 1'b1;
   end

   // Counting: one step per pulse unless a match clears it or the bus writes the counter
   counter_step_a: assert property (@(posedge pclk) disable iff (!presetn)
      tick && !equal && !(wr_en && hit_count) |=> count_value == $past(count_value) + 16'h0001);

   // A halted counter keeps its value
   counter_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      !running && !(wr_en && hit_count) |=> $stable(count_value));

   // Pulses at divide-by-four are never closer than four cycles
   div_four_a: assert property (@(posedge pclk) disable iff (!presetn)
      tick && clock_select == 2'h0 |=> !tick [*3]);

   // Every full period that does not follow a select change matches the selected ratio
   ratio_gap_a: assert property (@(posedge pclk) disable iff (!presetn)
      tick && gap_valid && !sel_changed |-> gap_count == gap_expect);

   // A match clears the counter and raises the flag
   match_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
      match_tick && !(wr_en && hit_count) |=> count_value == 16'h0000 && match_flag);

   // A match only acts on a counter pulse
   match_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
      dma_request |-> tick && equal);

   // Without a prior read of one, the flag is not cleared
   flag_one_a: assert property (@(posedge pclk) disable iff (!presetn)
      match_flag && !flag_seen |=> match_flag);

   // A control write without the read step leaves the flag alone
   flag_guard_a: assert property (@(posedge pclk) disable iff (!presetn)
      wr_en && hit_ctrl && !flag_seen && !match_tick |=> match_flag == $past(match_flag));

   // Reserved control bits read zero
   reserved_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
      rd_en && hit_ctrl |-> prdata[15:8] == 8'h00 && prdata[5:2] == 4'h0);

   // The spare bit stores what was written
   spare_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
      wr_en && hit_ctrl |=> spare_bit == $past(pwdata[6]));

   // The period constant only changes on a bus write
   period_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      !(wr_en && hit_period) |=> $stable(period_constant));

   // A request pulse leaves the flag and the status bit set
   request_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
      dma_request |=> match_flag && irq_status);

   // Prescaled clocks are single-cycle enables
   prescale_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
      tick |=> !tick);

   // Read data is zero outside a read access, so stale values never leak
   idle_read_a: assert property (@(posedge pclk) disable iff (!presetn)
      !rd_en |-> prdata == 32'h00000000);

   // Writing one to the status bit clears it when no match competes
   irq_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
      wr_en && hit_irq_st && pwdata[0] && !match_tick |=> !irq_status);

   // Main scenarios
   match_seen_c: cover property (@(posedge pclk) disable iff (!presetn) dma_request);
   flag_clear_c: cover property (@(posedge pclk) disable iff (!presetn) flag_clear);
   irq_raise_c: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
   div64_c: cover property (@(posedge pclk) disable iff (!presetn) tick && clock_select == 2'h3);
   gap_judged_c: cover property (@(posedge pclk) disable iff (!presetn)
      tick && gap_valid && !sel_changed);
endmodule

// File: testbench/cmt_timer_tb_top.sv
// Self-checking bench for the compare match period timer, driven over APB.
// Assumes cmt_timer and cmt_pkg; the bench drives every input port itself, one clock.
module cmt_timer_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        dma_request;
   logic        irq;
   logic [31:0] rd;
   logic        er;
   int          num_errors;
   int          total_checks;
   int          n;
   // Table rows: register address beside its value after reset
   logic [11:0] row_addr [6] = '{cmt_pkg::ADDR_START, cmt_pkg::ADDR_CTRL, cmt_pkg::ADDR_COUNT,
                                 cmt_pkg::ADDR_PERIOD, cmt_pkg::ADDR_IRQ_ST, cmt_pkg::ADDR_IRQ_MSK};
   logic [31:0] row_val [6] = '{32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
                                32'h0000_ffff, 32'h0000_0000, 32'h0000_0000};
   int          ratio [4] = '{4, 8, 16, 64};

   cmt_timer uut
   (
      .pclk        (pclk),
      .presetn     (presetn),
      .psel        (psel),
      .penable     (penable),
      .pwrite      (pwrite),
      .paddr       (paddr),
      .pwdata      (pwdata),
      .prdata      (prdata),
      .pready      (pready),
      .pslverr     (pslverr),
      .dma_request (dma_request),
      .irq         (irq)
   );

   // Free-running 250 MHz clock
   initial
   begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end

   // One APB transfer; held until pready is seen high, read data taken at that edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // Watchdog: fires after 50000 cycles; the whole sequence needs well under that
   initial
   begin
      #200000;
      num_errors++;
      tally_and_finish();
   end

   // Main sequence
   initial
   begin
      presetn = 1'b0;
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 12'h000;
      pwdata  = 32'h0000_0000;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 6; i++)
      begin
         apb(1'b0, row_addr[i], 32'h0000_0000);
         chk("reset value", row_val[i], rd);
      end
      // Period of one: a match every second tick, so spacing is twice the ratio
      apb(1'b1, cmt_pkg::ADDR_PERIOD, 32'h0000_0001);
      for (int c = 0; c < 4; c++)
      begin
         apb(1'b1, cmt_pkg::ADDR_CTRL, c);
         apb(1'b1, cmt_pkg::ADDR_START, 32'h0000_0001);
         n = 0;
         while (dma_request !== 1'b1 && n < 300)
         begin
            @(posedge pclk);
            n++;
         end
         n = 1;
         @(posedge pclk);
         while (dma_request !== 1'b1 && n < 300)
         begin
            @(posedge pclk);
            n++;
         end
         chk("match spacing", 2 * ratio[c], n);
         apb(1'b1, cmt_pkg::ADDR_START, 32'h0000_0000);
      end
      // Flag: writing one keeps it, writing zero after a read clears it
      apb(1'b0, cmt_pkg::ADDR_CTRL, 32'h0000_0000);
      chk("flag after match", 32'h0000_0083, rd);
      apb(1'b1, cmt_pkg::ADDR_CTRL, 32'h0000_0083);
      apb(1'b0, cmt_pkg::ADDR_CTRL, 32'h0000_0000);
      chk("flag after write one", 32'h0000_0083, rd);
      apb(1'b1, cmt_pkg::ADDR_CTRL, 32'h0000_0003);
      apb(1'b0, cmt_pkg::ADDR_CTRL, 32'h0000_0000);
      chk("flag after clear", 32'h0000_0003, rd);
      // Interrupt: masked, unmasked, then cleared by writing one
      chk("irq masked", 32'h0000_0000, {31'h0, irq});
      apb(1'b1, cmt_pkg::ADDR_IRQ_MSK, 32'h0000_0001);
      @(posedge pclk);
      chk("irq unmasked", 32'h0000_0001, {31'h0, irq});
      apb(1'b1, cmt_pkg::ADDR_IRQ_ST, 32'h0000_0001);
      @(posedge pclk);
      chk("irq cleared", 32'h0000_0000, {31'h0, irq});
      // Reserved bits read zero, spare bit six is stored
      apb(1'b1, cmt_pkg::ADDR_CTRL, 32'hffff_ff7f);
      apb(1'b0, cmt_pkg::ADDR_CTRL, 32'h0000_0000);
      chk("control readback", 32'h0000_0043, rd);
      // Counter and constant are read/write; a halted counter holds
      apb(1'b1, cmt_pkg::ADDR_COUNT, 32'h0000_1234);
      apb(1'b1, cmt_pkg::ADDR_PERIOD, 32'h0000_a5c3);
      repeat (100) @(posedge pclk);
      apb(1'b0, cmt_pkg::ADDR_COUNT, 32'h0000_0000);
      chk("halted count", 32'h0000_1234, rd);
      apb(1'b0, cmt_pkg::ADDR_PERIOD, 32'h0000_0000);
      chk("period readback", 32'h0000_a5c3, rd);
      // Unmapped address is refused and reads zero
      apb(1'b1, 12'h020, 32'h0000_0005);
      chk("unmapped write error", 32'h0000_0001, {31'h0, er});
      apb(1'b0, 12'h020, 32'h0000_0000);
      chk("unmapped read data", 32'h0000_0000, rd);
      chk("unmapped read error", 32'h0000_0001, {31'h0, er});
      // Second reset with the timer halted restores the period and count reset values
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, cmt_pkg::ADDR_PERIOD, 32'h0000_0000);
      chk("period after reset", 32'h0000_ffff, rd);
      apb(1'b0, cmt_pkg::ADDR_COUNT, 32'h0000_0000);
      chk("count after reset", 32'h0000_0000, rd);
      tally_and_finish();
   end
endmodule
